/* plbs_pkg.sv */
// Package for the circular-size and stack-pointer hazard latency block
package plbs_pkg;

    // Writer instruction kinds
    typedef enum logic [3:0] {
        WK_NONE,
        WK_IMM_OR_DMAD,
        WK_CONST_MOVE,
        WK_DD_POP_SP,
        WK_POP_DELAY_BK,
        WK_IMPLICIT_SP,
        WK_STORE
    } plbs_wkind_t;

    // Reader instruction forms
    typedef enum logic [3:0] {
        RF_OTHER,
        RF_MOVE_MAC,
        RF_ALU_SHIFT,
        RF_LOOP_BRANCH,
        RF_FIR_STEP,
        RF_GENERIC
    } plbs_rform_t;

    // Reader category
    typedef enum logic [1:0] {
        CAT_NONE,
        CAT_ONE,
        CAT_TWO
    } plbs_cat_t;

    // Register targets
    localparam logic [1:0] TGT_NONE = 2'h0;
    localparam logic [1:0] TGT_CIRC = 2'h1;
    localparam logic [1:0] TGT_STACK = 2'h2;

    // Extended shift range
    localparam int SHIFT_MIN = -16;
    localparam int SHIFT_MAX = 15;

    // Latency figures (cat I / cat II)
    localparam logic [2:0] LAT_ZERO = 3'h0;
    localparam logic [2:0] LAT_ONE = 3'h1;
    localparam logic [2:0] LAT_TWO = 3'h2;
    localparam logic [2:0] LAT_THREE = 3'h3;

    // Decoded writing instruction
    typedef struct packed {
        logic        valid;
        plbs_wkind_t kind;
        logic [1:0]  target;
        logic        indirect_dest;
    } plbs_wr_t;

    // Decoded reading instruction
    typedef struct packed {
        logic        valid;
        plbs_rform_t form;
        logic        circ_operand;
        logic        direct_operand;
        logic        long_offset;
        logic        ext_shift;
        logic signed [5:0] shift;
        logic        indirect_operand;
    } plbs_rd_t;

endpackage : plbs_pkg

/* plbs_latency.sv */
// Hazard latency evaluation for circular-size and stack-pointer writes
`timescale 1ns/1ps
module plbs_latency
    import plbs_pkg::*;
(
    // Clock and reset
    input  wire logic     mclk_i,
    input  wire logic     rstn_i,
    // Instruction stream
    input  wire logic     issue_i,
    input  wire plbs_wr_t wr_i,
    input  wire plbs_rd_t rd_i,
    // Conditions
    input  wire logic     compiler_mode_flag_i,
    input  wire logic     first_exec_update_i,
    input  wire logic     first_aux_long_load_i,
    input  wire logic     interrupt_i,
    // Results
    output logic [2:0]    latency_o,
    output plbs_cat_t     category_o,
    output logic          circ_conflict_o,
    output logic          stack_conflict_o,
    output logic          irq_stack_hazard_o,
    output logic          addr_gen_extra_o,
    output logic          postpone_o
);

    // Hazard detection
    logic       circ_hit;
    logic       stack_hit;
    logic       irq_stack;

    // Reader decode
    logic       shift_ok;
    logic       form_move_mac;
    logic       form_alu_shift;
    logic       form_loop_branch;
    logic       form_fir_step;
    logic       form_generic;
    logic       form_other;

    // Address-generator conflict
    logic       agen_conflict;
    logic       extra_marked;

    // Category per register
    plbs_cat_t  cat_circ;
    plbs_cat_t  cat_stack;
    plbs_cat_t  cat_d;

    // Latency columns and final figure
    logic [2:0] lat_cat_one;
    logic [2:0] lat_cat_two;
    logic [2:0] lat_d;
    logic       extra_d;
    logic [2:0] total_d;

    // Reader form decode
    assign form_move_mac    = (rd_i.form == RF_MOVE_MAC);
    assign form_alu_shift   = (rd_i.form == RF_ALU_SHIFT);
    assign form_loop_branch = (rd_i.form == RF_LOOP_BRANCH);
    assign form_fir_step    = (rd_i.form == RF_FIR_STEP);
    assign form_generic     = (rd_i.form == RF_GENERIC);
    assign form_other       = (rd_i.form == RF_OTHER);

    // Extended shift bound check
    assign shift_ok = rd_i.ext_shift && (rd_i.shift >= 6'(SHIFT_MIN)) && (rd_i.shift <= 6'(SHIFT_MAX));

    // Address-generator conflict of first instruction, suppressed by long-offset loads
    assign agen_conflict = first_exec_update_i && !first_aux_long_load_i;

    // Same-register hazard detection
    assign circ_hit  = wr_i.valid && rd_i.valid && (wr_i.target == TGT_CIRC)
                       && rd_i.circ_operand;
    assign stack_hit = wr_i.valid && rd_i.valid && (wr_i.target == TGT_STACK)
                       && compiler_mode_flag_i && rd_i.direct_operand;

    // Interrupt entry while the writer targets the stack pointer
    assign irq_stack = interrupt_i && wr_i.valid && (wr_i.target == TGT_STACK);

    // Circular-size reader category; any other circular user falls to Category I
    always_comb begin
        cat_circ = CAT_ONE;
        if (form_move_mac) begin
            cat_circ = rd_i.long_offset ? CAT_ONE : CAT_TWO;
        end else if (form_alu_shift && shift_ok) begin
            cat_circ = rd_i.long_offset ? CAT_ONE : CAT_TWO;
        end else if (form_fir_step && rd_i.indirect_operand) begin
            cat_circ = CAT_TWO;
        end else if (form_loop_branch) begin
            cat_circ = CAT_ONE;
        end else if (form_generic || form_other) begin
            cat_circ = CAT_ONE;
        end
    end

    // Stack-pointer reader category; listed direct forms are Category II
    always_comb begin
        cat_stack = CAT_ONE;
        if (form_move_mac) begin
            cat_stack = CAT_TWO;
        end else if (form_alu_shift && shift_ok) begin
            cat_stack = CAT_TWO;
        end
    end

    // Category of the register actually hit; no hit means no latency
    always_comb begin
        cat_d = CAT_NONE;
        if (circ_hit) begin
            cat_d = cat_circ;
        end else if (stack_hit) begin
            cat_d = cat_stack;
        end
    end

    // Latency columns by writer kind; marked kinds may add a conflict cycle
    always_comb begin
        lat_cat_one  = LAT_ZERO;
        lat_cat_two  = LAT_ZERO;
        extra_marked = 1'b0;
        unique case (wr_i.kind)
            WK_IMM_OR_DMAD: begin
                lat_cat_one  = LAT_ONE;
                lat_cat_two  = LAT_ZERO;
                extra_marked = 1'b1;
            end
            WK_CONST_MOVE: begin
                lat_cat_one = LAT_TWO;
                lat_cat_two = LAT_ONE;
            end
            WK_DD_POP_SP, WK_POP_DELAY_BK: begin
                lat_cat_one  = LAT_TWO;
                lat_cat_two  = LAT_ONE;
                extra_marked = 1'b1;
            end
            WK_IMPLICIT_SP: begin
                lat_cat_one = stack_hit ? LAT_ONE : LAT_ZERO;
                lat_cat_two = LAT_ZERO;
            end
            WK_STORE: begin
                lat_cat_one = LAT_THREE;
                lat_cat_two = LAT_TWO;
            end
            default: begin
                lat_cat_one = LAT_ZERO;
                lat_cat_two = LAT_ZERO;
            end
        endcase
    end

    // Column choice by reader category
    always_comb begin
        lat_d   = LAT_ZERO;
        extra_d = 1'b0;
        unique case (cat_d)
            CAT_ONE: begin
                lat_d   = lat_cat_one;
                extra_d = extra_marked && agen_conflict;
            end
            CAT_TWO: begin
                lat_d   = lat_cat_two;
                extra_d = extra_marked && agen_conflict;
            end
            CAT_NONE: begin
                lat_d   = LAT_ZERO;
                extra_d = 1'b0;
            end
            default: begin
                lat_d   = LAT_ZERO;
                extra_d = 1'b0;
            end
        endcase
    end

    // Table figure plus the conflict cycle; three at most, fits three bits
    assign total_d = lat_d + {2'h0, extra_d};

    // Required idle slots; software covers them, there is no stall
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            latency_o <= LAT_ZERO;
        end else if (issue_i) begin
            latency_o <= total_d;
        end
    end

    // Reader category
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            category_o <= CAT_NONE;
        end else if (issue_i) begin
            category_o <= cat_d;
        end
    end

    // Circular-size conflict flag
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            circ_conflict_o <= 1'b0;
        end else if (issue_i) begin
            circ_conflict_o <= circ_hit && (cat_d != CAT_NONE);
        end
    end

    // Stack-pointer conflict flag, direct use or interrupt entry
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stack_conflict_o <= 1'b0;
        end else if (issue_i) begin
            stack_conflict_o <= stack_hit || irq_stack;
        end
    end

    // Conflict cycle actually added
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            addr_gen_extra_o <= 1'b0;
        end else if (issue_i) begin
            addr_gen_extra_o <= extra_d;
        end
    end

    // Interrupt entry next to a stack-pointer write
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_stack_hazard_o <= 1'b0;
        end else begin
            irq_stack_hazard_o <= irq_stack;
        end
    end

    // Read-stage update after execute-stage update is held one cycle
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            postpone_o <= 1'b0;
        end else begin
            postpone_o <= issue_i && wr_i.valid && (wr_i.kind == WK_IMM_OR_DMAD) && agen_conflict;
        end
    end

endmodule : plbs_latency

/* plbs_latency_asserts.sv */
// Checker for the hazard latency block, bound to its ports
`timescale 1ns/1ps
module plbs_latency_asserts
    import plbs_pkg::*;
(
    // Clock, reset and inputs
    input wire logic mclk_i, rstn_i, issue_i,
    input wire plbs_wr_t wr_i,
    input wire plbs_rd_t rd_i,
    input wire logic compiler_mode_flag_i, first_exec_update_i, first_aux_long_load_i, interrupt_i,
    // Results
    input wire logic [2:0] latency_o,
    input wire plbs_cat_t category_o,
    input wire logic circ_conflict_o, stack_conflict_o, irq_stack_hazard_o, addr_gen_extra_o, postpone_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    // Valid pair issued this edge, by register written
    wire cst = issue_i & wr_i.valid & rd_i.valid;
    wire bk  = cst & wr_i.target == TGT_CIRC & rd_i.circ_operand;
    wire spd = cst & compiler_mode_flag_i & wr_i.target == TGT_STACK & rd_i.direct_operand;
    property p_hold; !issue_i |=> $stable(latency_o) && $stable(category_o); endproperty
    a_hold: assert property (p_hold) else $error("latency changed without issue");
    property p_st; bk & wr_i.kind == WK_STORE & rd_i.form == RF_MOVE_MAC
        |=> latency_o == 3'h2 + 3'($past(rd_i.long_offset)) && circ_conflict_o; endproperty
    a_st: assert property (p_st) else $error("store to size register latency wrong");
    property p_zero; issue_i & !bk & !spd |=> latency_o == 3'h0 && category_o == CAT_NONE; endproperty
    a_zero: assert property (p_zero) else $error("uncategorised reader not zero");
    property p_cpl; issue_i & !compiler_mode_flag_i & !interrupt_i & wr_i.target == TGT_STACK
        |=> latency_o == 3'h0 && !stack_conflict_o; endproperty
    a_cpl: assert property (p_cpl) else $error("stack hazard outside compiler mode");
    property p_irq; interrupt_i & wr_i.valid & wr_i.target == TGT_STACK |=> irq_stack_hazard_o; endproperty
    a_irq: assert property (p_irq) else $error("interrupt stack hazard missed");
    property p_dag; bk & wr_i.kind == WK_IMM_OR_DMAD & rd_i.form == RF_MOVE_MAC & rd_i.long_offset
        |=> latency_o == 3'h1 + 3'($past(first_exec_update_i & !first_aux_long_load_i)); endproperty
    a_dag: assert property (p_dag) else $error("address conflict cycle wrong");
    property p_sp14; spd & wr_i.kind == WK_STORE & rd_i.form == RF_MOVE_MAC
        |=> latency_o == 3'h2 && category_o == CAT_TWO && stack_conflict_o; endproperty
    a_sp14: assert property (p_sp14) else $error("store to stack latency wrong");
    property p_sp13; spd & wr_i.kind == WK_IMPLICIT_SP & rd_i.form == RF_GENERIC
        |=> latency_o == 3'h1 && category_o == CAT_ONE; endproperty
    a_sp13: assert property (p_sp13) else $error("implicit stack change latency wrong");
endmodule : plbs_latency_asserts
bind plbs_latency plbs_latency_asserts u_chk (.*);

/* plbs_latency_test.sv */
// Self-checking bench for the hazard latency block
`timescale 1ns/1ps
module plbs_latency_test;
    import plbs_pkg::*;
    logic       mclk_i = 0, rstn_i = 0, issue_i = 0, cm = 0, fx = 0, al = 0, irq = 0;
    plbs_wr_t   wr_i = '0;
    plbs_rd_t   rd_i = '0;
    logic [2:0] latency_o;
    plbs_cat_t  category_o;
    logic       cc, sc, ih, ax, pp;
    int         n_errors = 0, check_count = 0;
    plbs_latency i_dut (.mclk_i, .rstn_i, .issue_i, .wr_i, .rd_i, .compiler_mode_flag_i(cm),
        .first_exec_update_i(fx), .first_aux_long_load_i(al), .interrupt_i(irq), .latency_o,
        .category_o, .circ_conflict_o(cc), .stack_conflict_o(sc), .irq_stack_hazard_o(ih),
        .addr_gen_extra_o(ax), .postpone_o(pp));
    // 40 MHz clock
    initial forever #12.5 mclk_i = ~mclk_i;
    task automatic chk(string n, logic [3:0] e, logic [3:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk
    // Issue one pair; m = circ, direct, long offset, ext shift, indirect
    task automatic go(plbs_wkind_t k, logic [1:0] t, plbs_rform_t f, logic [4:0] m, logic [2:0] l, plbs_cat_t c);
        wr_i = '{1'b1, k, t, 1'b0};
        rd_i = '{1'b1, f, m[4], m[3], m[2], m[1], 6'sh0, m[0]};
        issue_i = 1;
        @(posedge mclk_i);
        #2 chk("latency", {1'b0, l}, {1'b0, latency_o});
        if (l != 0) chk("category", {2'b0, c}, {2'b0, category_o});
    endtask : go
    task automatic t_circ;
        go(WK_STORE, TGT_CIRC, RF_MOVE_MAC, 5'h14, 3'h3, CAT_ONE);
        chk("circ conflict", 4'h1, {3'b0, cc});
        chk("stack conflict", 4'h0, {3'b0, sc});
        go(WK_STORE, TGT_CIRC, RF_MOVE_MAC, 5'h10, 3'h2, CAT_TWO);
        go(WK_STORE, TGT_CIRC, RF_ALU_SHIFT, 5'h12, 3'h2, CAT_TWO);
        go(WK_STORE, TGT_CIRC, RF_FIR_STEP, 5'h11, 3'h2, CAT_TWO);
        go(WK_CONST_MOVE, TGT_CIRC, RF_LOOP_BRANCH, 5'h10, 3'h2, CAT_ONE);
        go(WK_IMM_OR_DMAD, TGT_CIRC, RF_GENERIC, 5'h10, 3'h1, CAT_ONE);
        $display("circular table done");
    endtask : t_circ
    task automatic t_addr_gen_unit;
        fx = 1;
        go(WK_IMM_OR_DMAD, TGT_CIRC, RF_MOVE_MAC, 5'h14, 3'h2, CAT_ONE);
        chk("addr gen extra", 4'h1, {3'b0, ax});
        chk("postpone", 4'h1, {3'b0, pp});
        go(WK_POP_DELAY_BK, TGT_CIRC, RF_MOVE_MAC, 5'h10, 3'h2, CAT_TWO);
        go(WK_CONST_MOVE, TGT_CIRC, RF_MOVE_MAC, 5'h14, 3'h2, CAT_ONE);
        al = 1;
        go(WK_IMM_OR_DMAD, TGT_CIRC, RF_MOVE_MAC, 5'h14, 3'h1, CAT_ONE);
        chk("addr gen extra", 4'h0, {3'b0, ax});
        chk("postpone", 4'h0, {3'b0, pp});
        fx = 0;
        al = 0;
        $display("address conflict done");
    endtask : t_addr_gen_unit
    task automatic t_stack;
        cm = 1;
        go(WK_STORE, TGT_STACK, RF_GENERIC, 5'h08, 3'h3, CAT_ONE);
        chk("stack conflict", 4'h1, {3'b0, sc});
        chk("circ conflict", 4'h0, {3'b0, cc});
        go(WK_STORE, TGT_STACK, RF_MOVE_MAC, 5'h08, 3'h2, CAT_TWO);
        go(WK_STORE, TGT_STACK, RF_ALU_SHIFT, 5'h0a, 3'h2, CAT_TWO);
        go(WK_CONST_MOVE, TGT_STACK, RF_GENERIC, 5'h08, 3'h2, CAT_ONE);
        go(WK_DD_POP_SP, TGT_STACK, RF_GENERIC, 5'h08, 3'h2, CAT_ONE);
        go(WK_IMPLICIT_SP, TGT_STACK, RF_GENERIC, 5'h08, 3'h1, CAT_ONE);
        go(WK_IMM_OR_DMAD, TGT_STACK, RF_GENERIC, 5'h08, 3'h1, CAT_ONE);
        go(WK_STORE, TGT_STACK, RF_MOVE_MAC, 5'h10, 3'h0, CAT_NONE);
        cm = 0;
        go(WK_STORE, TGT_STACK, RF_GENERIC, 5'h08, 3'h0, CAT_NONE);
        chk("stack conflict", 4'h0, {3'b0, sc});
        $display("stack table done");
    endtask : t_stack
    task automatic t_zero;
        go(WK_STORE, TGT_CIRC, RF_OTHER, 5'h04, 3'h0, CAT_NONE);
        go(WK_STORE, TGT_CIRC, RF_MOVE_MAC, 5'h00, 3'h0, CAT_NONE);
        $display("zero latency done");
    endtask : t_zero
    task automatic t_irq;
        issue_i = 0;
        irq = 1;
        wr_i = '{1'b1, WK_STORE, TGT_STACK, 1'b0};
        @(posedge mclk_i);
        #2 chk("irq hazard", 4'h1, {3'b0, ih});
        wr_i.target = TGT_CIRC;
        @(posedge mclk_i);
        #2 chk("irq hazard", 4'h0, {3'b0, ih});
        irq = 0;
        $display("interrupt done");
    endtask : t_irq
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk_i);
        #2 rstn_i = 1;
        t_circ();
        t_addr_gen_unit();
        t_stack();
        t_zero();
        t_irq();
        complete_run();
    end
    // Watchdog
    initial begin
        #25000;
        n_errors++;
        complete_run();
    end
endmodule : plbs_latency_test
